// file: core/link_rx_regs.sv
// Link receiver register bank: transport self check, lane inversion, lane 0 parameters
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module link_rx_regs import link_regs_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic [LANES*8-1:0] lane_data_out,
  output logic link_config_ok,
  link_if.rx link
);
  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  // One wait state: pready rises after the first access edge, and writes land
  // only at the completion edge, where the master samples pready high
  logic access;
  logic wr_en;
  logic rd_en;
  logic [11:0] idx;
  logic mapped;
  assign access = psel && penable && !pready;
  assign idx = paddr[13:2];
  assign wr_en = psel && penable && pready && pwrite && mapped;
  assign rd_en = access && !pwrite && mapped;

  function automatic logic is_mapped(input logic [11:0] i, input logic [1:0] lo);
    is_mapped = (lo == 2'h0) && (i == IDX_CHECK_CONTROL || i == IDX_CHECK_REF_LOW ||
      i == IDX_CHECK_REF_HIGH || i == IDX_CHECK_RESULT || i == IDX_LINK_CONFIG ||
      i == IDX_LANE_INVERT || i == IDX_RX_DEVICE_IDENT || i == IDX_RX_BANK_ADJUST ||
      i == IDX_RX_LANE0_IDENT || i == IDX_IRQ_STATUS || i == IDX_IRQ_MASK) &&
      (paddr[31:14] == 18'h00000);
  endfunction
  assign mapped = is_mapped(idx, paddr[1:0]);

  // ------------------------------------------------------------
  // Writable registers
  // ------------------------------------------------------------
  logic [5:0] control_reg;
  logic [7:0] ref_low_reg;
  logic [7:0] ref_high_reg;
  logic [7:0] link_config_reg;
  logic [7:0] lane_invert_reg;
  logic [1:0] irq_mask_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_reg <= 6'h00;
      ref_low_reg <= RESET_BYTE;
      ref_high_reg <= RESET_BYTE;
      link_config_reg <= RESET_BYTE;
      lane_invert_reg <= RESET_BYTE;
      irq_mask_reg <= 2'h0;
    end else if (wr_en) begin
      case (idx)
        IDX_CHECK_CONTROL: control_reg <= pwdata[5:0];
        IDX_CHECK_REF_LOW: ref_low_reg <= pwdata[7:0]; // RULE_05
        IDX_CHECK_REF_HIGH: ref_high_reg <= pwdata[7:0]; // RULE_05
        IDX_LINK_CONFIG: link_config_reg <= pwdata[7:0]; // RULE_07
        IDX_LANE_INVERT: lane_invert_reg <= pwdata[7:0];
        IDX_IRQ_MASK: irq_mask_reg <= pwdata[1:0];
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Transport self check
  // ------------------------------------------------------------
  logic check_enable;
  logic check_result_clear;
  logic [1:0] check_channel_select;
  logic [1:0] check_sample_index;
  logic [15:0] expected_sample;
  logic [15:0] selected_sample;
  logic chan_valid;
  logic mismatch;
  logic check_fail_flag;
  assign check_enable = control_reg[CTL_ENABLE_BIT];
  assign check_result_clear = control_reg[CTL_CLEAR_BIT];
  assign check_channel_select = control_reg[CTL_CHAN_LSB +: 2];
  assign check_sample_index = control_reg[CTL_SAMPLE_LSB +: 2];
  assign expected_sample = {ref_high_reg, ref_low_reg}; // RULE_05
  // Codes 1 and 3 pick no channel, so no check runs on them
  assign chan_valid = (check_channel_select == CHAN_ZERO) ||
    (check_channel_select == CHAN_ONE); // RULE_02
  always_comb begin
    if (check_channel_select == CHAN_ONE) begin
      selected_sample = link.chan1_samples[check_sample_index*SAMPLE_W +: SAMPLE_W]; // RULE_01 RULE_02
    end else begin
      selected_sample = link.chan0_samples[check_sample_index*SAMPLE_W +: SAMPLE_W]; // RULE_01 RULE_02
    end
  end
  assign mismatch = check_enable && chan_valid && link.samples_valid &&
    (selected_sample != expected_sample); // RULE_04 RULE_05

  // Clear bit is level-held: while it stays 1 the result is kept reset,
  // but a mismatch in the same cycle wins over the clear and sets the flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      check_fail_flag <= 1'b0;
    end else if (mismatch) begin
      check_fail_flag <= 1'b1; // RULE_06 RULE_15
    end else if (check_result_clear) begin
      check_fail_flag <= 1'b0; // RULE_03
    end
  end

  // ------------------------------------------------------------
  // Lane inversion
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lane_data_out <= '0;
    end else begin
      for (int l = 0; l < LANES; l++) begin
        lane_data_out[l*8 +: 8] <= link.lane_data[l*8 +: 8] ^ {8{lane_invert_reg[l]}}; // RULE_08
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_config_ok <= 1'b0;
    end else begin
      link_config_ok <= (link_config_reg == LINK_CONFIG_REQUIRED); // RULE_07
    end
  end

  // ------------------------------------------------------------
  // Lane 0 link parameter capture
  // ------------------------------------------------------------
  logic [7:0] rx_device_ident_reg;
  logic [7:0] rx_bank_adjust_reg;
  logic [7:0] rx_lane0_ident_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_device_ident_reg <= RESET_BYTE;
      rx_bank_adjust_reg <= RESET_BYTE;
      rx_lane0_ident_reg <= RESET_BYTE;
    end else if (link.param_valid) begin
      rx_device_ident_reg <= link.param_device_ident; // RULE_09
      rx_bank_adjust_reg <= link.param_bank_adjust; // RULE_10 RULE_11
      // Top bit is reserved and always reads zero
      rx_lane0_ident_reg <= {1'b0, link.param_lane_ident[LID_ADJDIR_BIT],
        link.param_lane_ident[LID_PHADJ_BIT], link.param_lane_ident[4:0]}; // RULE_12 RULE_13 RULE_14
    end
  end

  // ------------------------------------------------------------
  // Interrupts
  // ------------------------------------------------------------
  logic [1:0] irq_status_reg;
  logic [1:0] irq_events;
  logic status_read;
  assign irq_events = {link.param_valid, mismatch};
  assign status_read = rd_en && (idx == IDX_IRQ_STATUS);
  // A new event in the read cycle survives the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_reg <= 2'h0;
    end else begin
      irq_status_reg <= (status_read ? 2'h0 : irq_status_reg) | irq_events;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((status_read ? 2'h0 : irq_status_reg) | irq_events) & irq_mask_reg);
    end
  end

  // ------------------------------------------------------------
  // Read data and answer
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= access;
      pslverr <= access && !mapped;
      prdata <= 32'h00000000;
      if (rd_en) begin
        case (idx)
          IDX_CHECK_CONTROL: prdata <= {26'h0000000, control_reg};
          IDX_CHECK_REF_LOW: prdata <= {24'h000000, ref_low_reg};
          IDX_CHECK_REF_HIGH: prdata <= {24'h000000, ref_high_reg};
          IDX_CHECK_RESULT: prdata <= {31'h00000000, check_fail_flag}; // RULE_06
          IDX_LINK_CONFIG: prdata <= {24'h000000, link_config_reg};
          IDX_LANE_INVERT: prdata <= {24'h000000, lane_invert_reg};
          IDX_RX_DEVICE_IDENT: prdata <= {24'h000000, rx_device_ident_reg}; // RULE_09
          IDX_RX_BANK_ADJUST: prdata <= {24'h000000, rx_bank_adjust_reg}; // RULE_10 RULE_11
          IDX_RX_LANE0_IDENT: prdata <= {24'h000000, rx_lane0_ident_reg}; // RULE_14
          IDX_IRQ_STATUS: prdata <= {30'h00000000, irq_status_reg};
          IDX_IRQ_MASK: prdata <= {30'h00000000, irq_mask_reg};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// file: core/link_regs_pkg.sv
// Constants shared by the link receiver register bank and the link transmitter model
// Contract
// RULE_01 - Sample index picks the checked sample position
// RULE_02 - Channel select 0 or 2 picks converter
// RULE_03 - Writing one to clear resets result
// RULE_04 - Comparison runs only while enable set
// RULE_05 - Two reference bytes form expected sample
// RULE_06 - Result bit zero on match, one else
// RULE_07 - Software writes config byte 0x01; resets zero
// RULE_08 - Mask bit set inverts that lane's data
// RULE_09 - Expose received device identifier, read-only
// RULE_10 - Expose adjust resolution; transmitter sends zero
// RULE_11 - Expose received bank identifier, read-only
// RULE_12 - Expose direction flag bit six; sent zero
// RULE_13 - Expose phase request bit five; sent zero
// RULE_14 - Expose received five-bit lane identifier
// RULE_15 - Fail flag holds until software clears
package link_regs_pkg;
  // ------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------
  localparam int LANES = 8;
  localparam int SAMPLES = 4;
  localparam int SAMPLE_W = 16;
  localparam int REG_INDEX_W = 12;
  // ------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [11:0] IDX_CHECK_CONTROL = 12'h32C;
  localparam logic [11:0] IDX_CHECK_REF_LOW = 12'h32D;
  localparam logic [11:0] IDX_CHECK_REF_HIGH = 12'h32E;
  localparam logic [11:0] IDX_CHECK_RESULT = 12'h32F;
  localparam logic [11:0] IDX_LINK_CONFIG = 12'h333;
  localparam logic [11:0] IDX_LANE_INVERT = 12'h334;
  localparam logic [11:0] IDX_RX_DEVICE_IDENT = 12'h400;
  localparam logic [11:0] IDX_RX_BANK_ADJUST = 12'h401;
  localparam logic [11:0] IDX_RX_LANE0_IDENT = 12'h402;
  localparam logic [11:0] IDX_IRQ_STATUS = 12'h410;
  localparam logic [11:0] IDX_IRQ_MASK = 12'h411;
  // ------------------------------------------------------------
  // Fields and reset values
  // ------------------------------------------------------------
  localparam int CTL_ENABLE_BIT = 0;
  localparam int CTL_CLEAR_BIT = 1;
  localparam int CTL_CHAN_LSB = 2;
  localparam int CTL_SAMPLE_LSB = 4;
  localparam logic [1:0] CHAN_ZERO = 2'h0;
  localparam logic [1:0] CHAN_ONE = 2'h2;
  localparam int LID_PHADJ_BIT = 5;
  localparam int LID_ADJDIR_BIT = 6;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] LINK_CONFIG_REQUIRED = 8'h01;
  // Interrupt status bits: 0 check failed, 1 new link parameters captured
  localparam int IRQ_FAIL_BIT = 0;
  localparam int IRQ_PARAM_BIT = 1;
  // Transmitter parameter counter end value; parameters are sent every 64 clock cycles
  localparam logic [7:0] PARAM_PERIOD = 8'h3F;
endpackage

// file: core/link_if.sv
// Interface joining link receiver register bank and link transmitter
`timescale 1ns/1ps
`default_nettype none
interface link_if import link_regs_pkg::*; ();
  logic [LANES*8-1:0] lane_data;
  logic [SAMPLES*SAMPLE_W-1:0] chan0_samples;
  logic [SAMPLES*SAMPLE_W-1:0] chan1_samples;
  logic samples_valid;
  logic param_valid;
  logic [7:0] param_device_ident;
  logic [7:0] param_bank_adjust;
  logic [7:0] param_lane_ident;
  modport rx (input lane_data, chan0_samples, chan1_samples, samples_valid,
    param_valid, param_device_ident, param_bank_adjust, param_lane_ident);
  modport tx (output lane_data, chan0_samples, chan1_samples, samples_valid,
    param_valid, param_device_ident, param_bank_adjust, param_lane_ident);
endinterface
`default_nettype wire

// file: core/link_tx_end.sv
// Link transmitter end: drives samples, lane data and lane 0 parameters
`timescale 1ns/1ps
`default_nettype none
module link_tx_end import link_regs_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [LANES*8-1:0] tx_lane_data,
  input wire logic [SAMPLES*SAMPLE_W-1:0] tx_chan0_samples,
  input wire logic [SAMPLES*SAMPLE_W-1:0] tx_chan1_samples,
  input wire logic tx_samples_valid,
  input wire logic [7:0] tx_device_ident,
  input wire logic [3:0] tx_bank_ident,
  input wire logic [4:0] tx_lane_ident,
  link_if.tx link
);
  logic [7:0] period_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_reg <= 8'h00;
      link.param_valid <= 1'b0;
      link.param_device_ident <= 8'h00;
      link.param_bank_adjust <= 8'h00;
      link.param_lane_ident <= 8'h00;
    end else begin
      link.param_valid <= (period_reg == PARAM_PERIOD);
      period_reg <= (period_reg == PARAM_PERIOD) ? 8'h00 : period_reg + 8'h01;
      link.param_device_ident <= tx_device_ident;
      // Adjustment resolution always sent as zero
      link.param_bank_adjust <= {4'h0, tx_bank_ident}; // RULE_10
      // Direction and phase request always sent as zero
      link.param_lane_ident <= {1'b0, 1'b0, 1'b0, tx_lane_ident}; // RULE_12 RULE_13
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.lane_data <= '0;
      link.chan0_samples <= '0;
      link.chan1_samples <= '0;
      link.samples_valid <= 1'b0;
    end else begin
      link.lane_data <= tx_lane_data;
      link.chan0_samples <= tx_chan0_samples;
      link.chan1_samples <= tx_chan1_samples;
      link.samples_valid <= tx_samples_valid;
    end
  end
endmodule
`default_nettype wire

// file: tb/link_rx_chk.sv
// Concurrent checks on the link interface and the register bank's bus side
`timescale 1ns/1ps
`default_nettype none
module link_rx_chk import link_regs_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [LANES*8-1:0] lane_data_out,
  input wire logic [LANES*8-1:0] lane_data,
  input wire logic param_valid,
  input wire logic [7:0] param_bank_adjust,
  input wire logic [7:0] param_lane_ident
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_adjust_res_zero:
    assert property (param_valid |-> param_bank_adjust[7:4] == 4'h0) else $error("resolution sent");
  chk_dir_flag_zero:
    assert property (param_valid |-> !param_lane_ident[6]) else $error("direction flag sent");
  chk_phase_flag_zero:
    assert property (param_valid |-> !param_lane_ident[5]) else $error("phase request sent");
  chk_param_period:
    assert property (param_valid |-> ##64 param_valid) else $error("parameter period wrong");
  // Either plain or inverted one cycle later; the mask itself is not visible here
  chk_lane0_invert:
    assert property ($past(presetn) |-> lane_data_out[7:0] == $past(lane_data[7:0])
      || lane_data_out[7:0] == ~$past(lane_data[7:0])) else $error("lane 0 data wrong");
  chk_lane7_invert:
    assert property ($past(presetn) |-> lane_data_out[63:56] == $past(lane_data[63:56])
      || lane_data_out[63:56] == ~$past(lane_data[63:56])) else $error("lane 7 data wrong");
  chk_ready_pulse:
    assert property (pready |=> !pready) else $error("ready longer than one cycle");
  chk_ready_in_access:
    assert property (pready |-> psel && penable) else $error("ready outside access");
  chk_err_with_ready:
    assert property (pslverr |-> pready) else $error("error without ready");
  cover property (param_valid);
  cover property (pslverr);
  cover property ($past(presetn) && lane_data_out[7:0] == ~$past(lane_data[7:0]));
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for both link ends joined by the link interface
`timescale 1ns/1ps
`default_nettype none
module testbench import link_regs_pkg::*; ;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, r;
  logic pready, pslverr, irq, link_config_ok, e;
  logic tx_samples_valid = 1'b1;
  logic [63:0] lane_data_out, tx_lane_data = 64'h0123456789ABCDEF;
  logic [63:0] tx_chan0_samples = 64'h1003100210011000;
  logic [63:0] tx_chan1_samples = 64'hA003A002A001A000;
  logic [7:0] tx_device_ident = 8'h5A;
  logic [3:0] tx_bank_ident = 4'h9;
  logic [4:0] tx_lane_ident = 5'h13;
  int n_errors = 0, samples_checked = 0, cycles = 0;
  always #50 pclk = ~pclk;
  link_if link();
  link_tx_end i_link_tx_end(.pclk, .presetn, .tx_lane_data, .tx_chan0_samples, .tx_chan1_samples,
    .tx_samples_valid, .tx_device_ident, .tx_bank_ident, .tx_lane_ident, .link(link));
  link_rx_regs i_link_rx_regs(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq, .lane_data_out, .link_config_ok, .link(link));
  link_rx_chk i_link_rx_chk(.pclk, .presetn, .psel, .penable, .pready, .pslverr, .lane_data_out,
    .lane_data(link.lane_data), .param_valid(link.param_valid),
    .param_bank_adjust(link.param_bank_adjust), .param_lane_ident(link.param_lane_ident));
  // ------------------------------------------------------------
  // Bus and compare tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [63:0] ex, input logic [63:0] got);
    samples_checked++;
    if (got !== ex) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // Extra idle edge at the end so back-to-back calls never assign psel twice in one step
  task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {18'h0, idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] idx, input logic [7:0] ex);
    apb(1'b0, idx, 8'h00);
    chk($sformatf("register %h", idx), {56'h0, ex}, {32'h0, r});
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic s_regs();
    logic [11:0] all [9] = '{IDX_CHECK_CONTROL, IDX_CHECK_REF_LOW, IDX_CHECK_REF_HIGH,
      IDX_CHECK_RESULT, IDX_LINK_CONFIG, IDX_LANE_INVERT, IDX_RX_DEVICE_IDENT,
      IDX_RX_BANK_ADJUST, IDX_RX_LANE0_IDENT};
    foreach (all[i]) rd(all[i], RESET_BYTE);
    chk("config ok", 64'h0, {63'h0, link_config_ok});
    apb(1'b1, IDX_LINK_CONFIG, LINK_CONFIG_REQUIRED);
    @(posedge pclk);
    chk("config ok", 64'h1, {63'h0, link_config_ok});
    apb(1'b1, IDX_CHECK_RESULT, 8'hFF);
    rd(IDX_CHECK_RESULT, 8'h00);
    apb(1'b1, IDX_CHECK_REF_HIGH, 8'hC3);
    rd(IDX_CHECK_REF_HIGH, 8'hC3);
    apb(1'b0, 12'h3FF, 8'h00);
    chk("unmapped error", 64'h1, {63'h0, e});
    chk("unmapped data", 64'h0, {32'h0, r});
  endtask
  task automatic s_invert();
    logic [63:0] ex;
    logic [7:0] m = 8'hA5;
    apb(1'b1, IDX_LANE_INVERT, m);
    rd(IDX_LANE_INVERT, m);
    for (int l = 0; l < 8; l++) ex[8*l+:8] = tx_lane_data[8*l+:8] ^ {8{m[l]}};
    chk("lane data", ex, lane_data_out);
  endtask
  task automatic s_params();
    apb(1'b1, IDX_IRQ_MASK, 8'h02);
    while (irq !== 1'b1) @(posedge pclk);
    apb(1'b1, IDX_RX_DEVICE_IDENT, 8'h00);
    rd(IDX_RX_DEVICE_IDENT, 8'h5A);
    rd(IDX_RX_BANK_ADJUST, 8'h09);
    rd(IDX_RX_LANE0_IDENT, 8'h13);
    apb(1'b0, IDX_IRQ_STATUS, 8'h00);
    chk("param event", 64'h2, {32'h0, r & 32'h2});
    @(posedge pclk);
    chk("irq cleared", 64'h0, {63'h0, irq});
    apb(1'b1, IDX_IRQ_MASK, 8'h00);
  endtask
  // In the loop the reference moves only while the check is off, so no stray mismatch is latched
  task automatic s_check();
    logic [15:0] v;
    for (int c = 0; c < 2; c++) for (int s = 0; s < 4; s++) begin
      v = {c ? 8'hA0 : 8'h10, 6'h00, 2'(s)};
      apb(1'b1, IDX_CHECK_CONTROL, 8'h02);
      apb(1'b1, IDX_CHECK_REF_LOW, v[7:0]);
      apb(1'b1, IDX_CHECK_REF_HIGH, v[15:8]);
      apb(1'b1, IDX_CHECK_CONTROL, {2'h0, 2'(s), c ? CHAN_ONE : CHAN_ZERO, 2'h1});
      rd(IDX_CHECK_RESULT, 8'h00);
    end
    apb(1'b1, IDX_CHECK_REF_LOW, 8'h02);
    rd(IDX_CHECK_RESULT, 8'h01);
    chk("irq masked", 64'h0, {63'h0, irq});
    apb(1'b0, IDX_IRQ_STATUS, 8'h00);
    chk("fail event", 64'h1, {32'h0, r & 32'h1});
    apb(1'b1, IDX_CHECK_REF_LOW, 8'h03);
    rd(IDX_CHECK_RESULT, 8'h01);
    apb(1'b1, IDX_CHECK_CONTROL, 8'h3B);
    rd(IDX_CHECK_RESULT, 8'h00);
    apb(1'b1, IDX_CHECK_CONTROL, 8'h38);
    apb(1'b1, IDX_CHECK_REF_LOW, 8'h02);
    rd(IDX_CHECK_RESULT, 8'h00);
    // Channel code 1 picks no converter, so a differing reference must not fail
    apb(1'b1, IDX_CHECK_CONTROL, 8'h35);
    rd(IDX_CHECK_RESULT, 8'h00);
  endtask
  task automatic tally_and_finish();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    s_regs();
    s_invert();
    s_params();
    s_check();
    tally_and_finish();
  end
endmodule
`default_nettype wire
